// ### hdl/mrb_pkg.sv
// constants, types and register map of the reset, brown-out and idle block
`default_nettype none
package mrb_pkg;
    // bus geometry
    localparam int WB_ADR_W = 8;
    localparam int WB_DAT_W = 32;
    localparam int WB_SEL_W = 4;
    localparam int REG_W = 8;
    // register byte addresses
    localparam logic [WB_ADR_W-1:0] ADR_AUX_IRQ_EN = 8'hE8;
    localparam logic [WB_ADR_W-1:0] ADR_POWER_CTRL = 8'hF0;
    localparam logic [WB_ADR_W-1:0] ADR_FLASH_CFG = 8'hF4;
    localparam logic [WB_ADR_W-1:0] ADR_WDOG_CTRL = 8'hF8;
    localparam logic [WB_ADR_W-1:0] ADR_STATUS = 8'hFC;
    // field positions
    localparam int IDLE_BIT = 0;
    localparam int POF_BIT = 4;
    localparam int SWR_BIT = 1;
    localparam int WATCHDOG_RESET_FLAG_BIT = 2;
    localparam int EBO_BIT = 3;
    localparam int ST_BOD_BIT = 0;
    localparam int ST_IDLE_BIT = 1;
    localparam int ST_RST_BIT = 2;
    localparam int ST_CAUSE_LSB = 4;
    // reset values
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;
    // vectors
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] BOD_VECTOR = 16'h004B;
    // timing: clock and machine cycle
    localparam int CLK_HZ = 20_000_000;
    localparam int CLKS_PER_MCYC = 12;
    localparam int RST_PIN_MCYC = 2;
    localparam int RST_PIN_CLKS = RST_PIN_MCYC * CLKS_PER_MCYC;
    localparam int INT_RST_MCYC = 2;
    localparam int BOD_FILTER_CLKS = 4;
    // packed bus carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [WB_ADR_W-1:0] adr;
        logic [WB_SEL_W-1:0] sel;
        logic [WB_DAT_W-1:0] dat;
    } mrb_wb_req_s;
    typedef struct packed {
        logic ack;
        logic [WB_DAT_W-1:0] dat;
    } mrb_wb_rsp_s;
    // sequencer states and reset causes
    typedef enum logic [1:0] {ST_POWERUP, ST_RESET, ST_RUN} mrb_state_e;
    typedef enum logic [1:0] {
        CAUSE_POWER, CAUSE_PIN, CAUSE_SOFT, CAUSE_BOD
    } mrb_cause_e;
endpackage : mrb_pkg
`default_nettype wire

// ### hdl/mrb_reset_idle.sv
// reset qualification, brown-out handling and idle control with its registers
// Operation
// - reset restarts fetch at 0000H
// - strobes weakly pulled high during reset
// - reset leaves on-chip RAM untouched
// - every register reloads reset value; here the power-on and watchdog flags reload only at power-up
// - power-up reset weakly pulls ports high
// - power-on flag set, software clears
// - soft reset on soft bit rising
// - soft reset keeps soft bit, watchdog flag
// - brown-out needs four low clocks
// - brown-out without enable resets, 0000H
// - enabled brown-out interrupts at 004BH
// - enable cleared while active resets
// - idle halts program counter only
// - interrupt start or reset ends idle
// - resume after instruction entering idle
// - reset in idle acts like power-on
// - idle bit is power control bit0
// - strobes driven high during idle
//
// Chosen here: the Wishbone interface to the registers.
`default_nettype none
module mrb_reset_idle (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire mrb_pkg::mrb_wb_req_s wb_req_i,
    output mrb_pkg::mrb_wb_rsp_s wb_rsp_o,
    input wire logic rst_pin_i,
    input wire logic osc_stable_i,
    input wire logic bod_below_i,
    input wire logic wdt_reset_i,
    input wire logic int_start_i,
    input wire logic core_ale_i,
    input wire logic core_program_store_strobe_n_n_i,
    output logic core_reset_o,
    output logic pc_load_o,
    output logic [15:0] pc_load_addr_o,
    output logic pc_halt_o,
    output logic brownout_irq_o,
    output logic [15:0] brownout_vector_o,
    output logic ale_o,
    output logic program_store_strobe_n_o,
    output logic strobe_weak_o,
    output logic port_pullup_o
);
    import mrb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic pin_meta, pin_sync; // reset pin synchroniser
    logic stab_meta, stab_sync; // oscillator-stable synchroniser
    logic bod_meta, bod_sync; // brown-out comparator synchroniser
    logic [3:0] mc_cnt; // clock count inside a machine cycle
    logic mc_tick; // one pulse per machine cycle
    logic [4:0] pin_cnt; // clocks the pin has been seen high
    logic pin_qual; // pin held long enough
    logic [2:0] bod_cnt; // clocks spent below threshold
    logic bod_active; // filtered brown-out condition
    logic bod_active_d; // previous value, for the rising edge
    logic ebo_d; // previous enable, for the falling edge
    logic [1:0] hold_cnt; // machine cycles of internal reset
    mrb_state_e state; // sequencer state
    mrb_cause_e cause; // what caused the current reset
    logic in_reset; // core held in reset
    logic [REG_W-1:0] aux_irq_enable_reg;
    logic idle_request_bit;
    logic power_on_flag;
    logic soft_reset_bit;
    logic watchdog_reset_flag;
    logic wb_fire; // request taken this cycle
    logic wr_en; // write to lane 0
    logic [REG_W-1:0] wdat; // write byte
    logic soft_trig, bod_trig, pin_trig, wdt_trig, any_trig;
    logic brownout_irq_enable;
    logic [REG_W-1:0] status_byte;
    logic [REG_W-1:0] rd_byte;

    assign in_reset = (state != ST_RUN);
    assign brownout_irq_enable = aux_irq_enable_reg[EBO_BIT];
    assign wb_fire = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
    assign wr_en = wb_fire & wb_req_i.we & wb_req_i.sel[0];
    assign wdat = wb_req_i.dat[REG_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers: the first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            stab_meta <= 1'b0;
            stab_sync <= 1'b0;
            bod_meta <= 1'b0;
            bod_sync <= 1'b0;
        end else begin
            pin_meta <= rst_pin_i;
            pin_sync <= pin_meta;
            stab_meta <= osc_stable_i;
            stab_sync <= stab_meta;
            bod_meta <= bod_below_i;
            bod_sync <= bod_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // machine cycle divider, an enable pulse every twelve clocks
    always_ff @(posedge clk_i) begin
        if (rst_i || mc_tick) begin
            mc_cnt <= '0;
        end else begin
            mc_cnt <= mc_cnt + 4'h1;
        end
    end
    assign mc_tick = (mc_cnt == 4'(CLKS_PER_MCYC - 1));

    ////////////////////////////////////////////////////////////////////////
    // pin qualification: counts only once the oscillator is stable, so a
    // pin held through start-up alone does not reset a second time early
    always_ff @(posedge clk_i) begin
        if (rst_i || !pin_sync || !stab_sync) begin
            pin_cnt <= '0;
        end else if (!pin_qual) begin
            pin_cnt <= pin_cnt + 5'h01;
        end
    end
    assign pin_qual = (pin_cnt == 5'(RST_PIN_CLKS));

    ////////////////////////////////////////////////////////////////////////
    // brown-out glitch filter: four consecutive low clocks
    always_ff @(posedge clk_i) begin
        if (rst_i || !bod_sync) begin
            bod_cnt <= '0;
        end else if (!bod_active) begin
            bod_cnt <= bod_cnt + 3'h1;
        end
    end
    assign bod_active = (bod_cnt == 3'(BOD_FILTER_CLKS));

    // edge history for brown-out and its enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bod_active_d <= 1'b0;
            ebo_d <= 1'b0;
        end else begin
            bod_active_d <= bod_active;
            ebo_d <= brownout_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset triggers; internal ones are ignored while already in reset
    assign pin_trig = pin_qual;
    assign soft_trig = wr_en && (wb_req_i.adr == ADR_FLASH_CFG)
        && wdat[SWR_BIT] && !soft_reset_bit;
    // default brown-out action is a reset unless the interrupt is enabled
    assign bod_trig = (bod_active && !bod_active_d && !brownout_irq_enable)
        || (bod_active && ebo_d && !brownout_irq_enable);
    assign wdt_trig = wdt_reset_i;
    assign any_trig = !in_reset && (soft_trig || bod_trig || wdt_trig);

    ////////////////////////////////////////////////////////////////////////
    // sequencer: power-up waits for the oscillator, reset holds the core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_POWERUP;
            cause <= CAUSE_POWER;
            hold_cnt <= '0;
        end else begin
            unique case (state)
                ST_POWERUP: begin
                    if (stab_sync) begin
                        state <= ST_RESET;
                        hold_cnt <= '0;
                    end
                end
                ST_RESET: begin
                    // pin keeps the core in reset as long as it is high
                    if (pin_sync) begin
                        hold_cnt <= '0;
                    end else if (hold_cnt == 2'(INT_RST_MCYC)) begin
                        state <= ST_RUN;
                    end else if (mc_tick) begin
                        hold_cnt <= hold_cnt + 2'h1;
                    end
                end
                ST_RUN: begin
                    if (pin_trig) begin
                        state <= ST_RESET;
                        cause <= CAUSE_PIN;
                        hold_cnt <= '0;
                    end else if (any_trig) begin
                        state <= ST_RESET;
                        cause <= soft_trig ? CAUSE_SOFT : CAUSE_BOD;
                        hold_cnt <= '0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // auxiliary interrupt enable: plain storage, cleared by every reset
    always_ff @(posedge clk_i) begin
        if (rst_i || in_reset) begin
            aux_irq_enable_reg <= REG_RESET;
        end else if (wr_en && wb_req_i.adr == ADR_AUX_IRQ_EN) begin
            aux_irq_enable_reg <= wdat;
        end
    end

    // idle bit: a write in the same cycle as interrupt start wins, so an
    // idle entry is never dropped; the core then leaves on the next start
    always_ff @(posedge clk_i) begin
        if (rst_i || in_reset) begin
            idle_request_bit <= 1'b0;
        end else if (wr_en && wb_req_i.adr == ADR_POWER_CTRL) begin
            idle_request_bit <= wdat[IDLE_BIT];
        end else if (int_start_i) begin
            idle_request_bit <= 1'b0;
        end
    end

    // power-on flag: only power-up sets it; kept by every later reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_on_flag <= 1'b1;
        end else if (wr_en && wb_req_i.adr == ADR_POWER_CTRL
                     && !wdat[POF_BIT]) begin
            power_on_flag <= 1'b0;
        end
    end

    // soft reset bit survives the reset it triggered
    always_ff @(posedge clk_i) begin
        if (rst_i || (in_reset && cause != CAUSE_SOFT)) begin
            soft_reset_bit <= 1'b0;
        end else if (in_reset) begin
            soft_reset_bit <= soft_reset_bit;
        end else if (wr_en && wb_req_i.adr == ADR_FLASH_CFG) begin
            soft_reset_bit <= wdat[SWR_BIT];
        end
    end

    // watchdog flag: hardware set wins over a software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_reset_flag <= 1'b0;
        end else if (wdt_reset_i) begin
            watchdog_reset_flag <= 1'b1;
        end else if (wr_en && wb_req_i.adr == ADR_WDOG_CTRL
                     && !wdat[WATCHDOG_RESET_FLAG_BIT]) begin
            watchdog_reset_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero and still acknowledge
    always_comb begin
        status_byte = '0;
        status_byte[ST_BOD_BIT] = bod_active;
        status_byte[ST_IDLE_BIT] = idle_request_bit;
        status_byte[ST_RST_BIT] = in_reset;
        status_byte[ST_CAUSE_LSB +: 2] = cause;
        rd_byte = '0;
        case (wb_req_i.adr)
            ADR_AUX_IRQ_EN: rd_byte = aux_irq_enable_reg;
            ADR_POWER_CTRL: begin
                rd_byte[IDLE_BIT] = idle_request_bit;
                rd_byte[POF_BIT] = power_on_flag;
            end
            ADR_FLASH_CFG: rd_byte[SWR_BIT] = soft_reset_bit;
            ADR_WDOG_CTRL: rd_byte[WATCHDOG_RESET_FLAG_BIT] = watchdog_reset_flag;
            ADR_STATUS: rd_byte = status_byte;
            default: rd_byte = '0;
        endcase
    end

    // classic slave: ack one clock after the request, one cycle wide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_rsp_o <= '0;
        end else begin
            wb_rsp_o.ack <= wb_fire;
            if (wb_fire && !wb_req_i.we) begin
                wb_rsp_o.dat <= {{(WB_DAT_W-REG_W){1'b0}}, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core controls; no RAM clear exists here, so resets keep RAM
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_reset_o <= 1'b1;
            pc_load_o <= 1'b0;
            pc_load_addr_o <= RESET_VECTOR;
            pc_halt_o <= 1'b0;
            brownout_irq_o <= 1'b0;
            brownout_vector_o <= BOD_VECTOR;
        end else begin
            core_reset_o <= in_reset;
            // vector load as reset ends; idle exit never reloads
            pc_load_o <= (state == ST_RESET) && !pin_sync
                && (hold_cnt == 2'(INT_RST_MCYC));
            pc_load_addr_o <= RESET_VECTOR;
            pc_halt_o <= idle_request_bit;
            brownout_irq_o <= bod_active && brownout_irq_enable && !in_reset;
            brownout_vector_o <= BOD_VECTOR;
        end
    end

    // strobes: weak high in reset, driven high in idle, else the core's
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ale_o <= 1'b1;
            program_store_strobe_n_o <= 1'b1;
            strobe_weak_o <= 1'b1;
            port_pullup_o <= 1'b1;
        end else begin
            ale_o <= (in_reset || idle_request_bit) ? 1'b1
                : core_ale_i;
            program_store_strobe_n_o <= (in_reset || idle_request_bit)
                ? 1'b1 : core_program_store_strobe_n_n_i;
            strobe_weak_o <= in_reset;
            port_pullup_o <= in_reset && (cause == CAUSE_POWER
                || cause == CAUSE_PIN);
        end
    end
endmodule : mrb_reset_idle
`default_nettype wire

// ### verification/mrb_ext_model.sv
// model of the reset circuit and the core strobes around the block
`default_nettype none
module mrb_ext_model (
    input wire logic clk_i,
    output logic rst_pin_o,
    output logic osc_stable_o,
    output logic core_ale_o,
    output logic core_program_store_strobe_n_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import mrb_pkg::*;
    localparam int OSC_START_CLKS = 40; // start-up span, plain default
    ////////////////////////////////////////////////////////////////////////
    // power-up: pin held through start-up and two machine cycles plus four clocks more
    initial begin
        rst_pin_o = 1'b1;
        osc_stable_o = 1'b0;
        core_ale_o = 1'b0;
        core_program_store_strobe_n_n_o = 1'b1;
        repeat (OSC_START_CLKS) @(posedge clk_i);
        osc_stable_o <= 1'b1;
        repeat (RST_PIN_CLKS + 4) @(posedge clk_i);
        rst_pin_o <= 1'b0;
    end
    // core strobes change every cycle so a stuck output shows
    always @(posedge clk_i) begin
        core_ale_o <= ~core_ale_o;
        core_program_store_strobe_n_n_o <= core_ale_o;
    end
    // pin pulse of n clocks; short ones must be ignored by the block
    task automatic pin_pulse(input int n);
        @(posedge clk_i);
        rst_pin_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_pin_o <= 1'b0;
    endtask : pin_pulse
endmodule : mrb_ext_model
`default_nettype wire

// ### verification/mrb_reset_idle_chk.sv
// port assertions of the reset, brown-out and idle block
`default_nettype none
module mrb_reset_idle_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire mrb_pkg::mrb_wb_req_s wb_req_i,
    input wire mrb_pkg::mrb_wb_rsp_s wb_rsp_o,
    input wire logic bod_below_i,
    input wire logic int_start_i,
    input wire logic core_reset_o,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_load_addr_o,
    input wire logic pc_halt_o,
    input wire logic brownout_irq_o,
    input wire logic [15:0] brownout_vector_o,
    input wire logic ale_o,
    input wire logic program_store_strobe_n_o,
    input wire logic strobe_weak_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import mrb_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] bod_cnt; // consecutive low-supply clocks, saturating
    ////////////////////////////////////////////////////////////////////////
    // saturate so a long brown-out never wraps back to a small count
    always_ff @(posedge clk_i) begin
        if (rst_i || !bod_below_i) begin
            bod_cnt <= 4'h0;
        end else if (bod_cnt != 4'hF) begin
            bod_cnt <= bod_cnt + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_ack_one;
        wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack late");
    property p_ack_pulse;
        wb_rsp_o.ack |=> !wb_rsp_o.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_weak_high;
        strobe_weak_o |-> ale_o && program_store_strobe_n_o;
    endproperty
    a_weak_high: assert property (p_weak_high)
        else $error("strobe low in reset");
    property p_idle_high;
        pc_halt_o && $past(pc_halt_o) |-> ale_o && program_store_strobe_n_o;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("strobe low in idle");
    property p_load_vec;
        pc_load_o |-> pc_load_addr_o == RESET_VECTOR ##1 !pc_load_o
            ##[0:1] !core_reset_o;
    endproperty
    a_load_vec: assert property (p_load_vec)
        else $error("restart load wrong");
    property p_bod_vec;
        brownout_irq_o |-> brownout_vector_o == BOD_VECTOR;
    endproperty
    a_bod_vec: assert property (p_bod_vec)
        else $error("brown-out vector wrong");
    // two sync stages, four filter clocks and the output register
    property p_bod_filter;
        $rose(brownout_irq_o) |-> bod_cnt >= 4'h7;
    endproperty
    a_bod_filter: assert property (p_bod_filter)
        else $error("brown-out taken too soon");
    property p_wake;
        pc_halt_o && int_start_i |-> ##[1:2] !pc_halt_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("idle not left on interrupt");
    property p_reset_wake;
        $rose(core_reset_o) |-> ##[0:2] !pc_halt_o;
    endproperty
    a_reset_wake: assert property (p_reset_wake)
        else $error("idle kept through reset");
    property p_halt_no_load;
        pc_halt_o |-> !pc_load_o;
    endproperty
    a_halt_no_load: assert property (p_halt_no_load)
        else $error("counter loaded while halted");
endmodule : mrb_reset_idle_chk
bind mrb_reset_idle mrb_reset_idle_chk mrb_reset_idle_chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .bod_below_i(bod_below_i),
    .int_start_i(int_start_i), .core_reset_o(core_reset_o),
    .pc_load_o(pc_load_o), .pc_load_addr_o(pc_load_addr_o),
    .pc_halt_o(pc_halt_o), .brownout_irq_o(brownout_irq_o),
    .brownout_vector_o(brownout_vector_o), .ale_o(ale_o),
    .program_store_strobe_n_o(program_store_strobe_n_o),
    .strobe_weak_o(strobe_weak_o)
);
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench of the reset, brown-out and idle block
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
    miscompares++; $display("wrong value %s exp %0h got %0h", nm, exp, got); \
    end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mrb_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    mrb_wb_req_s wb_req_i = '0; // idle bus
    mrb_wb_rsp_s wb_rsp_o;
    logic bod_below_i = 1'b0;
    logic int_start_i = 1'b0;
    logic wdt_reset_i = 1'b0;
    logic rst_pin_i, osc_stable_i, core_ale_i, core_program_store_strobe_n_n_i;
    logic core_reset_o, pc_load_o, pc_halt_o, brownout_irq_o;
    logic [15:0] pc_load_addr_o, brownout_vector_o;
    logic ale_o, program_store_strobe_n_o, strobe_weak_o, port_pullup_o;
    logic [31:0] rd; // last read data
    int miscompares = 0;
    int comparisons = 0;
    always #25 clk_i = ~clk_i;
    mrb_ext_model mrb_ext_model_inst (.clk_i(clk_i), .rst_pin_o(rst_pin_i),
        .osc_stable_o(osc_stable_i), .core_ale_o(core_ale_i),
        .core_program_store_strobe_n_n_o(core_program_store_strobe_n_n_i));
    // block under test; the watchdog event is a bench-driven pulse
    mrb_reset_idle mrb_reset_idle_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .rst_pin_i(rst_pin_i),
        .osc_stable_i(osc_stable_i), .bod_below_i(bod_below_i),
        .wdt_reset_i(wdt_reset_i), .int_start_i(int_start_i),
        .core_ale_i(core_ale_i), .core_program_store_strobe_n_n_i(core_program_store_strobe_n_n_i),
        .core_reset_o(core_reset_o), .pc_load_o(pc_load_o),
        .pc_load_addr_o(pc_load_addr_o), .pc_halt_o(pc_halt_o),
        .brownout_irq_o(brownout_irq_o),
        .brownout_vector_o(brownout_vector_o), .ale_o(ale_o),
        .program_store_strobe_n_o(program_store_strobe_n_o),
        .strobe_weak_o(strobe_weak_o), .port_pullup_o(port_pullup_o));
    ////////////////////////////////////////////////////////////////////////
    // one classic cycle; request held until ack is seen at an edge
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
        input logic [31:0] dat);
        int n = 0;
        wb_req_i <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
        @(posedge clk_i);
        while (wb_rsp_o.ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20) `CHK("ack", 1'b1, 1'b0)
        rd = wb_rsp_o.dat;
        wb_req_i <= '0;
        @(posedge clk_i);
    endtask : wb_cycle
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0);
        `CHK("read data", exp, rd)
    endtask : rd_chk
    // bounded wait for the core reset level
    task automatic wait_rst(input logic lvl);
        int n = 0;
        while (core_reset_o !== lvl && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        `CHK("core_reset_o", lvl, core_reset_o)
    endtask : wait_rst
    ////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        rd_chk(8'hF0, 32'h10);
        rd_chk(8'hE8, 32'h0);
        rd_chk(8'h10, 32'h0);
        `CHK("port_pullup_o", 1'b0, port_pullup_o)
        `CHK("strobe pass", ~ale_o, program_store_strobe_n_o)
        wb_cycle(1'b1, 8'hF0, 32'h0);
        rd_chk(8'hF0, 32'h0);
    endtask : t_power_up
    task automatic t_pin();
        wb_cycle(1'b1, 8'hE8, 32'h08);
        wb_cycle(1'b1, 8'hF0, 32'h01);
        mrb_ext_model_inst.pin_pulse(20);
        repeat (10) @(posedge clk_i);
        `CHK("short pin", 1'b0, core_reset_o)
        mrb_ext_model_inst.pin_pulse(30);
        wait_rst(1'b1);
        repeat (2) @(posedge clk_i);
        `CHK("pc_halt_o", 1'b0, pc_halt_o)
        `CHK("port_pullup_o", 1'b1, port_pullup_o)
        wait_rst(1'b0);
        rd_chk(8'hE8, 32'h0);
        rd_chk(8'hF0, 32'h0);
        rd_chk(8'hFC, 32'h10);
    endtask : t_pin
    task automatic t_soft();
        wdt_reset_i <= 1'b1;
        @(posedge clk_i);
        wdt_reset_i <= 1'b0;
        wait_rst(1'b1);
        wait_rst(1'b0);
        rd_chk(8'hF8, 32'h04);
        rd_chk(8'hFC, 32'h30);
        wb_cycle(1'b1, 8'hF4, 32'h02);
        wait_rst(1'b1);
        wait_rst(1'b0);
        rd_chk(8'hF4, 32'h02);
        rd_chk(8'hF8, 32'h04);
        rd_chk(8'hFC, 32'h20);
        wb_cycle(1'b1, 8'hF8, 32'h0);
        rd_chk(8'hF8, 32'h0);
        wb_cycle(1'b1, 8'hF4, 32'h02);
        repeat (4) @(posedge clk_i);
        `CHK("no edge", 1'b0, core_reset_o)
        wb_cycle(1'b1, 8'hF4, 32'h0);
    endtask : t_soft
    task automatic t_bod();
        bod_below_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        bod_below_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        `CHK("short dip", 1'b0, core_reset_o)
        bod_below_i <= 1'b1;
        wait_rst(1'b1);
        bod_below_i <= 1'b0;
        wait_rst(1'b0);
        wb_cycle(1'b1, 8'hE8, 32'h08);
        bod_below_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        `CHK("brownout_irq_o", 1'b1, brownout_irq_o)
        `CHK("no reset", 1'b0, core_reset_o)
        rd_chk(8'hFC, 32'h31);
        wb_cycle(1'b1, 8'hE8, 32'h0);
        wait_rst(1'b1);
        bod_below_i <= 1'b0;
        wait_rst(1'b0);
        `CHK("irq gone", 1'b0, brownout_irq_o)
    endtask : t_bod
    task automatic t_idle();
        wb_cycle(1'b1, 8'hF0, 32'h01);
        repeat (3) @(posedge clk_i);
        `CHK("pc_halt_o", 1'b1, pc_halt_o)
        rd_chk(8'hF0, 32'h01);
        `CHK("ale_o", 1'b1, ale_o)
        `CHK("program_store_strobe_n idle", 1'b1, program_store_strobe_n_o)
        int_start_i <= 1'b1;
        @(posedge clk_i);
        int_start_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK("woken", 1'b0, pc_halt_o)
        `CHK("resume", 1'b0, core_reset_o)
        rd_chk(8'hF0, 32'h0);
    endtask : t_idle
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // main sequence: power-up reset, then one task per behaviour
    initial begin
        repeat (6) @(posedge clk_i);
        `CHK("port_pullup_o", 1'b1, port_pullup_o)
        `CHK("strobe_weak_o", 1'b1, strobe_weak_o)
        rst_i <= 1'b0;
        wait_rst(1'b0);
        t_power_up();
        t_pin();
        t_soft();
        t_bod();
        t_idle();
        report_and_stop();
    end
    // tests take a few hundred clocks; this span of 30000 clocks is far beyond that
    initial begin
        #(50 * 30000);
        miscompares++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
